// file: common/flash_seq_pkg.sv
package flash_seq_pkg;

  // opcodes
  localparam logic [7:0] OP_READ      = 8'h03;
  localparam logic [7:0] OP_FAST      = 8'h0B;
  localparam logic [7:0] OP_DUAL      = 8'hBB;
  localparam logic [7:0] OP_QUAD      = 8'hEB;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_STAT_LOW  = 8'h05;
  localparam logic [7:0] OP_STAT_HIGH = 8'h35;
  localparam logic [7:0] OP_STAT_WRITE = 8'h01;
  localparam logic [3:0] CONT_KEEP    = 4'hA;

  // clocks per phase
  localparam logic [4:0] FAST_DUMMY_CLKS = 5'h08;
  localparam logic [4:0] QUAD_DUMMY_CLKS = 5'h04;
  localparam logic [4:0] STAT_BITS_ONE   = 5'h08;
  localparam logic [4:0] STAT_BITS_TWO   = 5'h10;
  localparam logic [4:0] STAT_BITS_OVER  = 5'h11;

  // status word layout
  localparam int BUSY_BIT        = 0;
  localparam int WEL_BIT         = 1;
  localparam int RANGE_LSB       = 2;
  localparam int FROM_BOTTOM_BIT = 5;
  localparam int GRANULE_BIT     = 6;
  localparam int LOCK_LOW_BIT    = 7;
  localparam int LOCK_HIGH_BIT   = 8;
  localparam int FOUR_LINE_BIT   = 9;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;
  localparam logic [15:0] STATUS_WR_MASK = 16'h03FC;

  // protection granules in bytes
  localparam int SMALL_GRANULE = 4096;
  localparam int LARGE_GRANULE = 65536;

  // timing
  localparam int CLK_PERIOD_NS        = 40;
  localparam int STATUS_WRITE_TIME_NS = 10000;
  localparam int STATUS_WRITE_CYCLES  =
    (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register map
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_MEM_ADDR = 8'h08;
  localparam logic [7:0] REG_MEM_DATA = 8'h0C;
  localparam int CTRL_EXT_BUSY_BIT = 0;
  localparam int CTRL_LOADER_BIT   = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] io;
  } spi_pins_s;

  localparam spi_pins_s PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};

  typedef enum {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY,
    ST_DATA, ST_STATUS, ST_SHORT, ST_WSTAT, ST_IGNORE
  } seq_state_e;

endpackage

// file: core/flash_array.sv
`timescale 1ns/1ps
`default_nettype none
module flash_array #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // write port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  // read port
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] cells [2**ADDR_W];
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;

  always_comb
  begin
    rd_data_nxt = cells[rd_addr];
  end

  always_ff @(posedge aclk)
  begin
    if (wr_en)
    begin
      cells[wr_addr] <= wr_data;
    end
    if (!aresetn)
    begin
      rd_data_r <= '0;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;

endmodule
`default_nettype wire

// file: core/flash_seq.sv
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module flash_seq
  import flash_seq_pkg::*;
#(
  parameter int ARRAY_ADDR_W = 12,
  parameter int AXI_ADDR_W   = 8
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // serial flash pins
  input  wire logic                  cs_n_pin,
  input  wire logic                  sclk_pin,
  input  wire logic [3:0]            io_in,
  output logic      [3:0]            io_out,
  output logic      [3:0]            io_oe,
  // axi4-lite write
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic      [1:0]            bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // axi4-lite read
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic      [31:0]           rdata,
  output logic      [1:0]            rresp,
  output logic                       rvalid,
  input  wire logic                  rready
);

  localparam int ARRAY_BYTES = 2**ARRAY_ADDR_W;

  // pin synchroniser: a bit changes once stages two and three agree
  spi_pins_s  meta_r, mid_r, late_r, lvl_r, lvl_nxt;
  spi_pins_s  pins_now;
  logic [5:0] agree;
  logic       sclk_rise, sclk_fall, cs_fall, cs_rise;

  assign pins_now = '{cs_n: cs_n_pin, sclk: sclk_pin, io: io_in};

  always_comb
  begin
    agree   = ~(mid_r ^ late_r);
    lvl_nxt = (late_r & agree) | (lvl_r & ~agree);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= PINS_IDLE;
      mid_r  <= PINS_IDLE;
      late_r <= PINS_IDLE;
      lvl_r  <= PINS_IDLE;
    end
    else
    begin
      meta_r <= pins_now;
      mid_r  <= meta_r;
      late_r <= mid_r;
      lvl_r  <= lvl_nxt;
    end
  end

  assign sclk_rise = lvl_nxt.sclk & ~lvl_r.sclk;
  assign sclk_fall = ~lvl_nxt.sclk & lvl_r.sclk;
  assign cs_fall   = ~lvl_nxt.cs_n & lvl_r.cs_n;
  assign cs_rise   = lvl_nxt.cs_n & ~lvl_r.cs_n;

  // sequencer state
  seq_state_e  state_r, state_nxt;
  logic [7:0]  cmd_r, cmd_nxt, cont_cmd_r, cont_cmd_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [7:0]  mode_r, mode_nxt, byte_r, byte_nxt;
  logic [2:0]  pos_r, pos_nxt;
  logic [3:0]  out_r, out_nxt, oe_r, oe_nxt;
  logic [15:0] status_r, status_nxt, wsr_r, wsr_nxt;
  logic [15:0] wtimer_r, wtimer_nxt;
  logic        wbusy_r, wbusy_nxt, cont_r, cont_nxt;

  // register-side state
  logic                  aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [AXI_ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0]           wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0]            wstrb_r, wstrb_nxt;
  logic                  bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]            bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic                  ext_busy_r, ext_busy_nxt, loader_r, loader_nxt;
  logic [23:0]           mem_addr_r, mem_addr_nxt;
  logic                  reject_r, reject_nxt;
  logic                  mem_we, prog_done, ext_done;

  logic                  busy;
  logic [15:0]           stat_view;
  logic [7:0]            mem_rdata;

  assign busy      = wbusy_r | ext_busy_r;
  assign stat_view = {status_r[15:1], busy};

  function automatic logic [2:0] lanes(input logic [7:0] op);
    case (op)
      OP_DUAL: lanes = 3'h2;
      OP_QUAD: lanes = 3'h4;
      default: lanes = 3'h1;
    endcase
  endfunction

  function automatic logic [4:0] addr_clks(input logic [7:0] op);
    case (op)
      OP_DUAL: addr_clks = 5'h0C;
      OP_QUAD: addr_clks = 5'h06;
      default: addr_clks = 5'h18;
    endcase
  endfunction

  // line 1 odd bits in dual, line 3 nibble msb in quad
  function automatic logic [23:0] shift_in(input logic [23:0] v,
                                           input logic [2:0]  w,
                                           input logic [3:0]  io);
    case (w)
      3'h2:    shift_in = {v[21:0], io[1:0]};
      3'h4:    shift_in = {v[19:0], io};
      default: shift_in = {v[22:0], io[0]};
    endcase
  endfunction

  function automatic logic prot_hit(input logic [15:0] st,
                                    input logic [23:0] a);
    logic [2:0]  bp;
    logic [24:0] size;
    logic [24:0] top;
    bp   = st[RANGE_LSB +: 3];
    size = st[GRANULE_BIT] ? 25'(SMALL_GRANULE) : 25'(LARGE_GRANULE);
    size = size << (bp - 3'h1);
    top  = 25'(ARRAY_BYTES);
    if (bp == 3'h0)
      prot_hit = 1'b0;
    else if (size >= top)
      prot_hit = 1'b1;
    else if (st[FROM_BOTTOM_BIT])
      prot_hit = {1'b0, a} < size;
    else
      prot_hit = {1'b0, a} >= (top - size);
  endfunction

  always_comb
  begin
    logic [7:0]  op;
    logic [7:0]  b;
    logic [23:0] m;
    logic [2:0]  w;
    op = {cmd_r[6:0], lvl_nxt.io[0]};
    b  = 8'h00;
    m  = 24'h000000;
    w  = lanes(cmd_r);
    state_nxt    = state_r;
    cmd_nxt      = cmd_r;
    cont_cmd_nxt = cont_cmd_r;
    cnt_nxt      = cnt_r;
    addr_nxt     = addr_r;
    mode_nxt     = mode_r;
    byte_nxt     = byte_r;
    pos_nxt      = pos_r;
    out_nxt      = out_r;
    oe_nxt       = oe_r;
    status_nxt   = status_r;
    wsr_nxt      = wsr_r;
    wtimer_nxt   = wtimer_r;
    wbusy_nxt    = wbusy_r;
    cont_nxt     = cont_r;
    // completions drop the latch; later sets override
    if (wbusy_r)
    begin
      if (wtimer_r == 16'h0001)
      begin
        wbusy_nxt           = 1'b0;
        status_nxt[WEL_BIT] = 1'b0;
      end
      else
      begin
        wtimer_nxt = wtimer_r - 16'h0001;
      end
    end
    if (prog_done || ext_done)
    begin
      status_nxt[WEL_BIT] = 1'b0;
    end
    if (cs_rise)
    begin
      state_nxt = ST_IDLE;
      oe_nxt    = 4'h0;
      if (state_r == ST_SHORT)
      begin
        if (cmd_r == OP_WR_ENABLE)
          status_nxt[WEL_BIT] = 1'b1;
        else
          status_nxt[WEL_BIT] = 1'b0;
      end
      else if (state_r == ST_WSTAT &&
               (cnt_r == STAT_BITS_ONE || cnt_r == STAT_BITS_TWO))
      begin
        // one byte leaves the upper byte zero
        if (cnt_r == STAT_BITS_TWO)
          b = wsr_r[7:0];
        else
          b = 8'h00;
        status_nxt = (status_nxt & ~STATUS_WR_MASK) |
                     ({b, (cnt_r == STAT_BITS_TWO) ? wsr_r[15:8]
                                                   : wsr_r[7:0]}
                      & STATUS_WR_MASK);
        wbusy_nxt  = 1'b1;
        wtimer_nxt = 16'(STATUS_WRITE_CYCLES);
      end
    end
    else if (cs_fall)
    begin
      cnt_nxt = 5'h00;
      pos_nxt = 3'h0;
      if (cont_r && !busy)
      begin
        state_nxt = ST_ADDR;
        cmd_nxt   = cont_cmd_r;
      end
      else
      begin
        state_nxt = ST_OPCODE;
      end
    end
    else if (!lvl_r.cs_n)
    begin
      case (state_r)
        ST_OPCODE:
        begin
          if (sclk_rise)
          begin
            cmd_nxt = op;
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == 5'h07)
            begin
              cnt_nxt = 5'h00;
              if (busy && op != OP_STAT_LOW && op != OP_STAT_HIGH)
                state_nxt = ST_IGNORE;
              else
              begin
                case (op)
                  OP_READ, OP_FAST, OP_DUAL: state_nxt = ST_ADDR;
                  OP_QUAD:
                    state_nxt = status_r[FOUR_LINE_BIT] ? ST_ADDR
                                                        : ST_IGNORE;
                  OP_WR_ENABLE, OP_WR_DISABLE: state_nxt = ST_SHORT;
                  OP_STAT_LOW, OP_STAT_HIGH: state_nxt = ST_STATUS;
                  OP_STAT_WRITE:
                    state_nxt = status_r[WEL_BIT] ? ST_WSTAT
                                                  : ST_IGNORE;
                  default: state_nxt = ST_IGNORE;
                endcase
              end
            end
          end
        end
        ST_ADDR:
        begin
          if (sclk_rise)
          begin
            addr_nxt = shift_in(addr_r, w, lvl_nxt.io);
            cnt_nxt  = cnt_r + 5'h01;
            if (cnt_r == addr_clks(cmd_r) - 5'h01)
            begin
              cnt_nxt = 5'h00;
              case (cmd_r)
                OP_READ: state_nxt = ST_DATA;
                OP_FAST: state_nxt = ST_DUMMY;
                default: state_nxt = ST_MODE;
              endcase
            end
          end
        end
        ST_MODE:
        begin
          if (sclk_rise)
          begin
            m        = shift_in({16'h0000, mode_r}, w, lvl_nxt.io);
            mode_nxt = m[7:0];
            cnt_nxt  = cnt_r + 5'h01;
            if (cnt_r == ((cmd_r == OP_QUAD) ? 5'h01 : 5'h03))
            begin
              cnt_nxt      = 5'h00;
              cont_nxt     = m[7:4] == CONT_KEEP;
              cont_cmd_nxt = cmd_r;
              state_nxt    = (cmd_r == OP_QUAD) ? ST_DUMMY : ST_DATA;
            end
          end
        end
        ST_DUMMY:
        begin
          // lines stay released during dummy clocks
          if (sclk_rise)
          begin
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == ((cmd_r == OP_FAST) ? FAST_DUMMY_CLKS
                                             : QUAD_DUMMY_CLKS) - 5'h01)
            begin
              cnt_nxt   = 5'h00;
              state_nxt = ST_DATA;
            end
          end
        end
        ST_DATA:
        begin
          if (sclk_fall)
          begin
            if (pos_r == 3'h0)
            begin
              b        = mem_rdata;
              addr_nxt = addr_r + 24'h000001;
            end
            else
            begin
              b = byte_r;
            end
            case (w)
              3'h2:
              begin
                out_nxt = {2'b00, b[7:6]};
                oe_nxt  = 4'h3;
              end
              3'h4:
              begin
                out_nxt = b[7:4];
                oe_nxt  = 4'hF;
              end
              default:
              begin
                out_nxt = {2'b00, b[7], 1'b0};
                oe_nxt  = 4'h2;
              end
            endcase
            byte_nxt = b << w;
            pos_nxt  = pos_r + w;
          end
        end
        ST_STATUS:
        begin
          if (sclk_fall)
          begin
            if (pos_r == 3'h0)
              b = (cmd_r == OP_STAT_LOW) ? stat_view[7:0]
                                         : stat_view[15:8];
            else
              b = byte_r;
            out_nxt  = {2'b00, b[7], 1'b0};
            oe_nxt   = 4'h2;
            byte_nxt = b << 1;
            pos_nxt  = pos_r + 3'h1;
          end
        end
        ST_SHORT:
        begin
          // extra clocks spoil a one-byte command
          if (sclk_rise)
            state_nxt = ST_IGNORE;
        end
        ST_WSTAT:
        begin
          if (sclk_rise)
          begin
            wsr_nxt = {wsr_r[14:0], lvl_nxt.io[0]};
            if (cnt_r != STAT_BITS_OVER)
              cnt_nxt = cnt_r + 5'h01;
          end
        end
        default:
        begin
          oe_nxt = 4'h0;
        end
      endcase
    end
    else
    begin
      state_nxt = ST_IDLE;
      oe_nxt    = 4'h0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r    <= ST_IDLE;
      cmd_r      <= 8'h00;
      cont_cmd_r <= 8'h00;
      cnt_r      <= 5'h00;
      addr_r     <= 24'h000000;
      mode_r     <= 8'h00;
      byte_r     <= 8'h00;
      pos_r      <= 3'h0;
      out_r      <= 4'h0;
      oe_r       <= 4'h0;
      status_r   <= STATUS_RESET;
      wsr_r      <= 16'h0000;
      wtimer_r   <= 16'h0000;
      wbusy_r    <= 1'b0;
      cont_r     <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      cmd_r      <= cmd_nxt;
      cont_cmd_r <= cont_cmd_nxt;
      cnt_r      <= cnt_nxt;
      addr_r     <= addr_nxt;
      mode_r     <= mode_nxt;
      byte_r     <= byte_nxt;
      pos_r      <= pos_nxt;
      out_r      <= out_nxt;
      oe_r       <= oe_nxt;
      status_r   <= status_nxt;
      wsr_r      <= wsr_nxt;
      wtimer_r   <= wtimer_nxt;
      wbusy_r    <= wbusy_nxt;
      cont_r     <= cont_nxt;
    end
  end

  assign io_out = out_r;
  assign io_oe  = oe_r;

  // register bus slave
  assign awready = !aw_held_r && !bvalid_r;
  assign wready  = !w_held_r && !bvalid_r;
  assign arready = !rvalid_r;

  always_comb
  begin
    logic       accept;
    logic [7:0] wa;
    logic [7:0] ra;
    accept       = 1'b0;
    wa           = {awaddr_r[7:2], 2'b00};
    ra           = {araddr[7:2], 2'b00};
    aw_held_nxt  = aw_held_r;
    w_held_nxt   = w_held_r;
    awaddr_nxt   = awaddr_r;
    wdata_nxt    = wdata_r;
    wstrb_nxt    = wstrb_r;
    bvalid_nxt   = bvalid_r;
    bresp_nxt    = bresp_r;
    rvalid_nxt   = rvalid_r;
    rdata_nxt    = rdata_r;
    rresp_nxt    = rresp_r;
    ext_busy_nxt = ext_busy_r;
    loader_nxt   = loader_r;
    mem_addr_nxt = mem_addr_r;
    reject_nxt   = reject_r;
    mem_we       = 1'b0;
    prog_done    = 1'b0;
    ext_done     = 1'b0;
    if (awvalid && awready)
    begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = awaddr;
    end
    if (wvalid && wready)
    begin
      w_held_nxt = 1'b1;
      wdata_nxt  = wdata;
      wstrb_nxt  = wstrb;
    end
    if (aw_held_r && w_held_r)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      case (wa)
        REG_CTRL:
          if (wstrb_r[0])
          begin
            ext_busy_nxt = wdata_r[CTRL_EXT_BUSY_BIT];
            loader_nxt   = wdata_r[CTRL_LOADER_BIT];
            ext_done     = ext_busy_r & ~wdata_r[CTRL_EXT_BUSY_BIT];
          end
        REG_STATUS: ;
        REG_MEM_ADDR:
          for (int i = 0; i < 3; i++)
            if (wstrb_r[i])
              mem_addr_nxt[8*i +: 8] = wdata_r[8*i +: 8];
        REG_MEM_DATA:
          if (wstrb_r[0])
          begin
            // a programming write needs the latch, idle, unprotected
            accept = loader_r || (status_r[WEL_BIT] && !busy &&
                                  !prot_hit(status_r, mem_addr_r));
            mem_we     = accept;
            prog_done  = accept && !loader_r;
            reject_nxt = !accept;
            if (accept)
              mem_addr_nxt = mem_addr_r + 24'h000001;
          end
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (bvalid_r && bready)
      bvalid_nxt = 1'b0;
    if (arvalid && arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      case (ra)
        REG_CTRL:     rdata_nxt = {30'h0, loader_r, ext_busy_r};
        REG_STATUS:   rdata_nxt = {15'h0, cont_r, stat_view};
        REG_MEM_ADDR: rdata_nxt = {8'h00, mem_addr_r};
        REG_MEM_DATA: rdata_nxt = {31'h0, reject_r};
        default:
        begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_r && rready)
      rvalid_nxt = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r  <= 1'b0;
      w_held_r   <= 1'b0;
      awaddr_r   <= '0;
      wdata_r    <= 32'h0;
      wstrb_r    <= 4'h0;
      bvalid_r   <= 1'b0;
      bresp_r    <= RESP_OKAY;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h0;
      rresp_r    <= RESP_OKAY;
      ext_busy_r <= 1'b0;
      loader_r   <= 1'b0;
      mem_addr_r <= 24'h000000;
      reject_r   <= 1'b0;
    end
    else
    begin
      aw_held_r  <= aw_held_nxt;
      w_held_r   <= w_held_nxt;
      awaddr_r   <= awaddr_nxt;
      wdata_r    <= wdata_nxt;
      wstrb_r    <= wstrb_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
      ext_busy_r <= ext_busy_nxt;
      loader_r   <= loader_nxt;
      mem_addr_r <= mem_addr_nxt;
      reject_r   <= reject_nxt;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp  = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata  = rdata_r;
  assign rresp  = rresp_r;

  // array wraps at its own size, so a stream covers the whole array
  flash_array #(
    .DATA_W (8),
    .ADDR_W (ARRAY_ADDR_W)
  ) u_array (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (mem_we),
    .wr_addr (mem_addr_r[ARRAY_ADDR_W-1:0]),
    .wr_data (wdata_r[7:0]),
    .rd_addr (addr_r[ARRAY_ADDR_W-1:0]),
    .rd_data (mem_rdata)
  );

endmodule
`default_nettype wire

// file: test/spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  // clock
  input  wire logic       aclk,
  // pins
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe,
  output logic            cs_n = 1'b1,
  output logic            sclk = 1'b0,
  output logic [3:0]      io_in
);
  logic [3:0] mosi = 4'h0;
  int         wl = 1;
  logic tgl = 1'b0;
  logic seen = 1'b0;
  // released lines toggle so a stale value never passes as data
  always_ff @(posedge aclk)
    tgl <= !tgl;
  always_comb
    for (int i = 0; i < 4; i++)
      io_in[i] = io_oe[i] ? io_out[i] : (!cs_n && i < wl) ? mosi[i] : tgl;
  task automatic sel(input logic v);
    @(posedge aclk);
    cs_n <= v;
    seen = seen && v;
    repeat (16) @(posedge aclk);
  endtask
  // whole bytes only, so writes end on a byte boundary
  task automatic xfer(input logic [7:0] tx, input int w,
                      output logic [7:0] rx);
    wl <= w;
    for (int i = 8 - w; i >= 0; i -= w)
    begin
      mosi <= 4'(tx >> i) & ((w == 2) ? 4'h3 : 4'h1);
      repeat (4) @(posedge aclk);
      sclk <= 1'b1;
      repeat (3) @(posedge aclk);
      if (w == 2)
        rx[i +: 2] = io_in[1:0];
      else
        rx[i] = io_in[1];
      seen = seen || (|io_oe);
      @(posedge aclk);
      sclk <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: test/flash_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module flash_seq_chk (
  // watched ports
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        cs_n_pin,
  input wire logic [3:0]  io_oe,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_idle_released: assert property (cs_n_pin [*8] |-> io_oe == 4'h0)
    else $error("pins driven while deselected");
  a_lane_shape: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("bad lane enable set");
  a_b_stands: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped");
  a_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer changed");
  a_aw_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during answer");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read taken during answer");
  a_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_b_answer: assert property
    (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
  cover property (rvalid && !rready);
  cover property (io_oe == 4'h2);
  cover property (bvalid && !bready);
endmodule
bind flash_seq flash_seq_chk u_chk (.*);
`default_nettype wire

// file: test/tb_flash_seq.sv
`timescale 1ns/1ps
`default_nettype none
module tb_flash_seq;
  import flash_seq_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        cs_n_pin, sclk_pin, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [3:0]  io_in, io_out, io_oe;
  logic [3:0]  wstrb = 4'hF;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  int          errors = 0;
  int          checked = 0;
  int          ones = 8;
  flash_seq uut (.*);
  spi_host host (.aclk, .io_out, .io_oe, .cs_n(cs_n_pin), .sclk(sclk_pin),
    .io_in);
  initial
    forever #20 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic ax(input logic wr, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q, output logic [1:0] r);
    logic ta, tw, tr, tb;
    @(posedge aclk);
    tb = 1'b0;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    arvalid <= !wr;
    for (int n = 0; n < 99 && !tb; n++)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      tb = bvalid && bready || rvalid && rready;
      q = rdata;
      r = wr ? bresp : rresp;
      @(posedge aclk);
      awvalid <= awvalid && !ta;
      wvalid <= wvalid && !tw;
      arvalid <= arvalid && !tr;
      bready <= wr && n > 1 && !tb;
      rready <= !wr && n > 1 && !tb;
    end
    chk(tb, 1'b1);
    if (!tb)
      report_and_stop();
  endtask
  task automatic spi(input int n, input logic [63:0] tx,
                     output logic [63:0] rx);
    host.sel(1'b0);
    for (int k = 0; k < n; k++)
      host.xfer(tx[63-8*k -: 8], (k < ones) ? 1 : 2, rx[63-8*k -: 8]);
    host.sel(1'b1);
  endtask
  task automatic stat(input logic [15:0] e);
    logic [63:0] a, b;
    spi(3, {OP_STAT_LOW, 56'h0}, a);
    spi(3, {OP_STAT_HIGH, 56'h0}, b);
    chk({b[55:40], a[55:40]}, {e[15:8], e[15:8], e[7:0], e[7:0]});
  endtask
  function automatic logic [15:0] st(input logic [15:0] v,
                                     input logic w, input logic b);
    return (v & STATUS_WR_MASK) | {14'h0, w, b};
  endfunction
  initial
  begin
    logic [63:0] rx;
    logic [31:0] q, mem;
    logic [1:0]  r;
    logic [15:0] v;
    logic [11:0] base;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    void'($urandom(23));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    stat(16'h0);
    spi(1, {OP_WR_ENABLE, 56'h0}, rx);
    stat(16'h0002);
    ax(1'b1, REG_CTRL, 32'h1, q, r);
    spi(5, {OP_READ, 32'h0, 24'h0}, rx);
    chk(host.seen, 1'b0);
    spi(1, {OP_WR_DISABLE, 56'h0}, rx);
    stat(16'h0003);
    ax(1'b1, REG_CTRL, 32'h0, q, r);
    stat(16'h0);
    spi(1, {OP_WR_ENABLE, 56'h0}, rx);
    spi(1, {OP_WR_DISABLE, 56'h0}, rx);
    v = 16'($urandom()) | 16'h0200;
    spi(3, {OP_STAT_WRITE, v[7:0], v[15:8], 40'h0}, rx);
    stat(16'h0);
    spi(1, {OP_WR_ENABLE, 56'h0}, rx);
    spi(3, {OP_STAT_WRITE, v[7:0], v[15:8], 40'h0}, rx);
    spi(2, {OP_STAT_LOW, 56'h0}, rx);
    chk(rx[55:48], 8'(st(v, 1'b1, 1'b1)));
    repeat (STATUS_WRITE_CYCLES) @(posedge aclk);
    stat(st(v, 1'b0, 1'b0));
    spi(1, {OP_WR_ENABLE, 56'h0}, rx);
    spi(2, {OP_STAT_WRITE, v[7:0], 48'h0}, rx);
    repeat (STATUS_WRITE_CYCLES) @(posedge aclk);
    stat(st(v & 16'h00FF, 1'b0, 1'b0));
    spi(1, {OP_WR_ENABLE, 56'h0}, rx);
    spi(4, {OP_STAT_WRITE, ~v[7:0], 48'h0}, rx);
    stat(st(v & 16'h00FF, 1'b1, 1'b0));
    base = 12'($urandom()) & 12'hFF0;
    mem = $urandom();
    ax(1'b1, REG_CTRL, 32'h2, q, r);
    ax(1'b1, REG_MEM_ADDR, {20'h0, base}, q, r);
    for (int k = 0; k < 4; k++)
      ax(1'b1, REG_MEM_DATA, {24'h0, mem[31-8*k -: 8]}, q, r);
    ax(1'b1, REG_CTRL, 32'h0, q, r);
    ax(1'b0, REG_MEM_ADDR, 32'h0, q, r);
    chk(q, {20'h0, base} + 32'h4);
    spi(1, {OP_WR_DISABLE, 56'h0}, rx);
    ax(1'b1, REG_MEM_DATA, 32'h0, q, r);
    ax(1'b0, REG_MEM_DATA, 32'h0, q, r);
    chk(q, 32'h1);
    spi(8, {OP_READ, 12'h0, base, mem}, rx);
    chk(rx[31:0], mem);
    spi(8, {OP_FAST, 12'h0, base + 12'h1, 32'h0}, rx);
    chk(rx[23:0], mem[23:0]);
    ones = 1;
    spi(8, {OP_DUAL, 12'h0, base, 8'hA5, 24'h0}, rx);
    chk(rx[23:0], mem[31:8]);
    ones = 0;
    spi(8, {12'h0, base + 12'h1, 8'h00, 32'h0}, rx);
    chk(rx[31:8], mem[23:0]);
    ones = 8;
    ax(1'b1, 8'h10, 32'h1, q, r);
    chk(r, RESP_SLVERR);
    ax(1'b0, 8'h10, 32'h0, q, r);
    chk(q, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    report_and_stop();
  end
endmodule
`default_nettype wire
